// [ecio_edge.sv]
`timescale 1ns/1ps
// three-stage sync; falling edge when stages two and three agree on a new low
module ecio_edge #(
	parameter int W = 7
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] lvl_reg;
	wire [W-1:0] agree = ~(s2_reg ^ s3_reg);
	wire [W-1:0] lvl_next = (agree & s3_reg) | (~agree & lvl_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			lvl_reg <= '1;
			fall_o <= '0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			fall_o <= lvl_reg & ~lvl_next;
		end
	end
endmodule

// [ecio_ext_ctl.sv]
`timescale 1ns/1ps
module ecio_ext_ctl (
	// clock
	input wire logic clk_i,
	// command request from the bench
	input wire logic [6:0] go_i,
	// connector lines
	output logic [6:0] pin_o
);
	logic [6:0] mask_reg = 7'h00;
	logic [3:0] cnt_reg = 4'h0;
	// pulled-up lines idle high; a command is a low pulse held past the sync stages
	assign pin_o = (cnt_reg != 4'h0) ? ~mask_reg : 7'h7F;
	always_ff @(posedge clk_i) begin
		if (go_i != 7'h00) begin
			mask_reg <= go_i;
			cnt_reg <= 4'h8;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule

// [ecio_pkg.sv]
// Notes on behaviour
// - pin shows source power state, 1 on
// - pin shows output enable state, 1 on
// - limiter pin high while any limiter acts
// - two sequence sync outputs and trigger output
// - command inputs act only when enabled
// - status outputs always driven, regardless of enable
package ecio_pkg;

	// command input bit positions
	localparam int CMD_OUT_OFF = 0;
	localparam int CMD_OUT_ON = 1;
	localparam int CMD_SEQ_START = 2;
	localparam int CMD_SEQ_STOP = 3;
	localparam int CMD_SEQ_HOLD = 4;
	localparam int CMD_SEQ_BR1 = 5;
	localparam int CMD_SEQ_BR2 = 6;
	localparam int CMD_W = 7;

	// event bit positions in status, clear and enable registers
	localparam int EV_OUT_ON = 0;
	localparam int EV_OUT_OFF = 1;
	localparam int EV_LIMIT = 2;
	localparam int EV_SEQ_START = 3;
	localparam int EV_SEQ_END = 4;
	localparam int EV_W = 5;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;

	// control register fields
	localparam int CTRL_EXT_EN = 0;
	localparam int CTRL_SRC_ON = 1;
	localparam int CTRL_BUSY = 2;
	localparam int CTRL_PK_POS = 3;
	localparam int CTRL_PK_NEG = 4;
	localparam int CTRL_RMS = 5;
	localparam int CTRL_PWR = 6;
	localparam int CTRL_TRIG = 7;
	localparam int CTRL_W = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h02;

	// trigger output pulse width
	localparam int TRIG_NS = 1000;
	localparam int CLK_NS = 25;
	localparam int TRIG_CYC = (TRIG_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		SEQ_IDLE = 4'h1,
		SEQ_RUN = 4'h2,
		SEQ_HOLD = 4'h4,
		SEQ_DONE = 4'h8
	} ecio_seq_t;

	// status pins, all registered
	typedef struct packed {
		logic src_on;
		logic out_on;
		logic limit;
		logic busy;
		logic [1:0] sync;
		logic trig;
	} ecio_stat_t;

	// limiter flags
	typedef struct packed {
		logic pk_pos;
		logic pk_neg;
		logic rms;
		logic pwr;
	} ecio_lim_t;

endpackage

// [ecio_top.sv]
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
module ecio_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// connector command inputs, pulled up, active on falling edge
	input wire logic [ecio_pkg::CMD_W-1:0] cmd_pin_i,
	// connector status outputs
	output logic src_on_o,
	output logic out_on_o,
	output logic limit_o,
	output logic busy_o,
	output logic [1:0] seq_sync_o,
	output logic trig_o,
	// interrupt
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// input edge detection

	logic [ecio_pkg::CMD_W-1:0] fall;

	ecio_edge #(.W(ecio_pkg::CMD_W)) u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(cmd_pin_i),
		.fall_o(fall)
	);

	////////////////////////////////////////////////////////////////////////
	// registers and bus decode

	logic [ecio_pkg::CTRL_W-1:0] ctrl_reg;
	logic [ecio_pkg::EV_W-1:0] ev_reg;
	logic [ecio_pkg::EV_W-1:0] ev_en_reg;
	logic out_on_reg;
	ecio_pkg::ecio_seq_t seq_reg;
	ecio_pkg::ecio_seq_t seq_next;
	logic [1:0] step_reg;
	logic [7:0] trig_cnt_reg;
	ecio_pkg::ecio_stat_t stat_next;
	ecio_pkg::ecio_lim_t lim;

	// one address decode shared by the write strobes and the read mux
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr == ofs;
	endfunction

	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire wr_ctrl = wr & hit(wb_adr_i, ecio_pkg::OFS_CTRL);
	wire wr_en = wr & hit(wb_adr_i, ecio_pkg::OFS_IRQ_EN);
	wire wr_clr = wr & hit(wb_adr_i, ecio_pkg::OFS_IRQ_CLR);
	wire trig_sw = wr_ctrl & wb_dat_i[ecio_pkg::CTRL_TRIG];

	// commands only act while external control is enabled
	wire ext_en = ctrl_reg[ecio_pkg::CTRL_EXT_EN];
	wire [ecio_pkg::CMD_W-1:0] cmd = fall & {ecio_pkg::CMD_W{ext_en}};

	////////////////////////////////////////////////////////////////////////
	// output enable and sequencer

	// off wins when both edges land together
	wire out_on_next = cmd[ecio_pkg::CMD_OUT_OFF] ? 1'b0 :
		cmd[ecio_pkg::CMD_OUT_ON] ? 1'b1 : out_on_reg;
	wire step_adv = (seq_reg == ecio_pkg::SEQ_RUN) &
		(cmd[ecio_pkg::CMD_SEQ_BR1] | cmd[ecio_pkg::CMD_SEQ_BR2]);
	wire [1:0] step_next = cmd[ecio_pkg::CMD_SEQ_START] ? 2'h0 :
		step_adv ? (cmd[ecio_pkg::CMD_SEQ_BR1] ? 2'h1 : 2'h2) : step_reg;

	always_comb begin
		seq_next = seq_reg;
		unique case (seq_reg)
			ecio_pkg::SEQ_IDLE, ecio_pkg::SEQ_DONE: begin
				if (cmd[ecio_pkg::CMD_SEQ_START]) begin
					seq_next = ecio_pkg::SEQ_RUN;
				end
			end
			ecio_pkg::SEQ_RUN: begin
				if (cmd[ecio_pkg::CMD_SEQ_STOP]) begin
					seq_next = ecio_pkg::SEQ_DONE;
				end else if (cmd[ecio_pkg::CMD_SEQ_HOLD]) begin
					seq_next = ecio_pkg::SEQ_HOLD;
				end
			end
			ecio_pkg::SEQ_HOLD: begin
				if (cmd[ecio_pkg::CMD_SEQ_STOP]) begin
					seq_next = ecio_pkg::SEQ_DONE;
				end else if (cmd[ecio_pkg::CMD_SEQ_START]) begin
					seq_next = ecio_pkg::SEQ_RUN;
				end
			end
			default: seq_next = ecio_pkg::SEQ_IDLE;
		endcase
	end

	wire seq_go = (seq_next == ecio_pkg::SEQ_RUN) & (seq_reg != ecio_pkg::SEQ_RUN);
	wire seq_end = (seq_next == ecio_pkg::SEQ_DONE) & (seq_reg != ecio_pkg::SEQ_DONE);
	wire trig_start = seq_go | step_adv | trig_sw;

	////////////////////////////////////////////////////////////////////////
	// status pins

	assign lim.pk_pos = ctrl_reg[ecio_pkg::CTRL_PK_POS];
	assign lim.pk_neg = ctrl_reg[ecio_pkg::CTRL_PK_NEG];
	assign lim.rms = ctrl_reg[ecio_pkg::CTRL_RMS];
	assign lim.pwr = ctrl_reg[ecio_pkg::CTRL_PWR];
	wire limit_on = |lim;

	assign stat_next.src_on = ctrl_reg[ecio_pkg::CTRL_SRC_ON];
	assign stat_next.out_on = out_on_reg;
	assign stat_next.limit = limit_on;
	assign stat_next.busy = ctrl_reg[ecio_pkg::CTRL_BUSY];
	assign stat_next.sync = step_reg;
	assign stat_next.trig = (trig_cnt_reg != 8'h00);

	////////////////////////////////////////////////////////////////////////
	// interrupt events, set wins over clear

	wire [ecio_pkg::EV_W-1:0] ev_set = {seq_end, seq_go, limit_on & ~limit_o,
		out_on_reg & ~out_on_next, ~out_on_reg & out_on_next};
	wire [ecio_pkg::EV_W-1:0] ev_clr = wr_clr ? wb_dat_i[ecio_pkg::EV_W-1:0] : '0;
	wire [ecio_pkg::EV_W-1:0] ev_next = ev_set | (ev_reg & ~ev_clr);

	wire [31:0] stat_word = {18'h0, seq_reg, step_reg, limit_on, out_on_reg,
		ctrl_reg[ecio_pkg::CTRL_SRC_ON], ext_en, 4'h0};
	wire [31:0] rd_data =
		hit(wb_adr_i, ecio_pkg::OFS_CTRL) ? {24'h0, ctrl_reg} :
		hit(wb_adr_i, ecio_pkg::OFS_STAT) ? stat_word :
		hit(wb_adr_i, ecio_pkg::OFS_IRQ_STAT) ? {27'h0, ev_reg} :
		hit(wb_adr_i, ecio_pkg::OFS_IRQ_EN) ? {27'h0, ev_en_reg} : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// state

	// the trigger bit is a strobe and is never stored
	wire [ecio_pkg::CTRL_W-1:0] ctrl_next = wr_ctrl ?
		{1'b0, wb_dat_i[ecio_pkg::CTRL_W-2:0]} : ctrl_reg;
	wire [ecio_pkg::EV_W-1:0] ev_en_next = wr_en ? wb_dat_i[ecio_pkg::EV_W-1:0] : ev_en_reg;
	// a new start or branch restarts a running pulse
	wire [7:0] trig_cnt_next = trig_start ? 8'(ecio_pkg::TRIG_CYC) :
		(trig_cnt_reg != 8'h00) ? trig_cnt_reg - 8'h01 : 8'h00;
	wire ack_next = req;
	wire [31:0] dat_next = (req & ~wb_we_i) ? rd_data : 32'h0;
	wire irq_next = |(ev_next & ev_en_reg);

	// software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= ecio_pkg::CTRL_RST;
			ev_en_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			ev_en_reg <= ev_en_next;
		end
	end

	// sticky events and the interrupt line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_reg <= '0;
			irq_o <= 1'b0;
		end else begin
			ev_reg <= ev_next;
			irq_o <= irq_next;
		end
	end

	// output enable state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_on_reg <= 1'b0;
		end else begin
			out_on_reg <= out_on_next;
		end
	end

	// sequencer state and step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_reg <= ecio_pkg::SEQ_IDLE;
			step_reg <= 2'h0;
		end else begin
			seq_reg <= seq_next;
			step_reg <= step_next;
		end
	end

	// trigger pulse counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_cnt_reg <= 8'h00;
		end else begin
			trig_cnt_reg <= trig_cnt_next;
		end
	end

	// bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= ack_next;
			wb_dat_o <= dat_next;
		end
	end

	// connector status pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{src_on_o, out_on_o, limit_o, busy_o, seq_sync_o, trig_o} <= '0;
		end else begin
			{src_on_o, out_on_o, limit_o, busy_o, seq_sync_o, trig_o} <= stat_next;
		end
	end

endmodule

// [ecio_top_chk.sv]
`timescale 1ns/1ps
module ecio_top_chk (
	// clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// connector
	input wire logic [ecio_pkg::CMD_W-1:0] cmd_pin_i,
	input wire logic src_on_o,
	input wire logic out_on_o,
	input wire logic limit_o,
	input wire logic trig_o
);
	logic [7:0] hi_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence wr_ctrl;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00 && wb_ack_o;
	endsequence
	always_ff @(posedge clk_i) begin
		hi_reg <= (rst_i || !trig_o) ? 8'h00 : hi_reg + 8'h01;
	end
	src_follow_a: assert property (wr_ctrl |-> ##2 src_on_o == $past(wb_dat_i[1], 2))
		else $error("source pin stale");
	limit_follow_a: assert property (wr_ctrl |-> ##2 limit_o == |$past(wb_dat_i[6:3], 2))
		else $error("limiter pin stale");
	ack_timing_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
		else $error("ack late");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	out_on_cmd_a: assert property ($rose(out_on_o) |-> !$past(cmd_pin_i[1], 3))
		else $error("output on without command");
	out_off_cmd_a: assert property ($fell(out_on_o) |-> !$past(cmd_pin_i[0], 3))
		else $error("output off without command");
	trig_width_a: assert property ($fell(trig_o) |-> hi_reg == 8'h28)
		else $error("trigger width wrong");
endmodule
bind ecio_top ecio_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_pin_i(cmd_pin_i),
	.src_on_o(src_on_o), .out_on_o(out_on_o), .limit_o(limit_o), .trig_o(trig_o));

// [ecio_top_tb.sv]
`timescale 1ns/1ps
module ecio_top_tb;
	logic clk_i = 0;
	logic rst_i = 1;
	logic wb_cyc_i = 0;
	logic wb_stb_i = 0;
	logic wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, src_on_o, out_on_o, limit_o, busy_o, trig_o, irq_o;
	logic [1:0] seq_sync_o;
	logic [6:0] cmd_pin_i;
	logic [6:0] go = 7'h00;
	logic [15:0] rnd = 16'h000F;
	logic [5:0] val;
	int failures = 0;
	int checks_done = 0;
	always #12.5 clk_i = ~clk_i;
	ecio_ext_ctl ctl_u (.clk_i(clk_i), .go_i(go), .pin_o(cmd_pin_i));
	ecio_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_pin_i(cmd_pin_i), .src_on_o(src_on_o),
		.out_on_o(out_on_o), .limit_o(limit_o), .busy_o(busy_o), .seq_sync_o(seq_sync_o),
		.trig_o(trig_o), .irq_o(irq_o));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic exp_limit(input logic [5:0] v);
		return |v[5:2];
	endfunction
	function automatic logic [31:0] ev_bit(input int pos);
		return 32'h1 << pos;
	endfunction
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cmp("ack_wait", 2, n);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic press(input int i);
		go <= 7'h01 << i;
		@(posedge clk_i);
		go <= 7'h00;
		repeat (16) @(posedge clk_i);
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		cmp("src_on", 1, src_on_o);
		wb(1, 8'h20, 32'h3);
		wb(0, 8'h20, 32'h0);
		cmp("unmapped", 0, rd);
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			val = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : rnd[5:0];
			wb(1, ecio_pkg::OFS_CTRL, {25'h0, val, 1'b0});
			cmp("src_on", val[0], src_on_o);
			cmp("busy", val[1], busy_o);
			cmp("limit", exp_limit(val), limit_o);
		end
		press(ecio_pkg::CMD_OUT_ON);
		cmp("out_on", 0, out_on_o);
		// trigger bit starts a pulse and reads back clear
		wb(1, ecio_pkg::OFS_CTRL, 32'h83);
		cmp("trig", 1, trig_o);
		wb(0, ecio_pkg::OFS_CTRL, 32'h0);
		cmp("ctrl", 32'h3, rd);
		wb(1, ecio_pkg::OFS_IRQ_EN, 32'h1);
		press(ecio_pkg::CMD_OUT_ON);
		cmp("out_on", 1, out_on_o);
		cmp("irq", 1, irq_o);
		wb(1, ecio_pkg::OFS_IRQ_EN, 32'h0);
		cmp("irq", 0, irq_o);
		wb(1, ecio_pkg::OFS_IRQ_EN, 32'h1);
		wb(1, ecio_pkg::OFS_IRQ_CLR, 32'h1);
		cmp("irq", 0, irq_o);
		press(ecio_pkg::CMD_OUT_OFF);
		cmp("out_on", 0, out_on_o);
		for (int i = 0; i < 3; i++) begin
			press(i ? ecio_pkg::CMD_SEQ_START + 2 + i : ecio_pkg::CMD_SEQ_START);
			cmp("trig", 1, trig_o);
			cmp("sync", i, seq_sync_o);
			repeat (45) @(posedge clk_i);
		end
		press(ecio_pkg::CMD_SEQ_HOLD);
		press(ecio_pkg::CMD_SEQ_BR1);
		cmp("sync", 2, seq_sync_o);
		wb(0, ecio_pkg::OFS_STAT, 32'h0);
		cmp("stat_seq", {4'h4, 2'h2}, rd[13:8]);
		press(ecio_pkg::CMD_SEQ_START);
		cmp("trig", 1, trig_o);
		cmp("sync", 0, seq_sync_o);
		press(ecio_pkg::CMD_SEQ_STOP);
		wb(0, ecio_pkg::OFS_STAT, 32'h0);
		cmp("stat_seq", {4'h8, 2'h0}, rd[13:8]);
		wb(0, ecio_pkg::OFS_IRQ_STAT, 32'h0);
		cmp("irq_stat", ev_bit(ecio_pkg::EV_OUT_OFF) | ev_bit(ecio_pkg::EV_LIMIT) |
			ev_bit(ecio_pkg::EV_SEQ_START) | ev_bit(ecio_pkg::EV_SEQ_END), rd);
		wb(1, ecio_pkg::OFS_IRQ_CLR, 32'h1F);
		wb(0, ecio_pkg::OFS_IRQ_STAT, 32'h0);
		cmp("irq_stat", 0, rd);
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		end_of_test();
	end
endmodule
